// File: core/diag_adc_sequencer.sv
// sequencer for the on-chip diagnostic converter
// assumes the serial front end gives one-cycle write and frame-start strobes on clk_i
// How it works
// - the low five bits of an accepted setup write steer the input multiplexer.
// - each input code other than 11110 maps to a fixed node, reserved codes select nothing.
// - code 11110 takes its node from a 2-bit regulator die sub-selection, 11 reserved.
// - a setup write with 100 in bits 10:8 and 000 in bits 7:5 starts exactly one conversion.
// - a finished conversion loads its result into the status register.
// - status keeps the last completed result and its code until the next completes.
// - the frame carrying a new command still shows the earlier result.
// - a frame after completion shows the new result and code.
// - a frame during a conversion shows the old result with busy set.
// - commands received while busy are dropped, never queued.
// - in automatic status mode every frame shifts out the status word.
// - status has busy at 17, code at 16:12 and result at 11:0.
`timescale 1ns/1ps
`default_nettype none
module diag_adc_sequencer (
    // clock and reset
    input  wire logic                               clk_i,
    input  wire logic                               rst_n_i,
    // register writes from the serial front end
    input  wire logic                               setup_wr_i,
    input  wire logic [diag_adc_pkg::SETUP_W-1:0]   setup_data_i,
    input  wire logic [1:0]                         regulator_die_probe_choice_i,
    // serial frame status readback
    input  wire logic                               frame_start_i,
    input  wire logic                               auto_status_en_i,
    output logic      [diag_adc_pkg::STATUS_W-1:0]  frame_status_o,
    output logic                                    frame_status_valid_o,
    // analog converter side
    output logic      [diag_adc_pkg::NODE_W-1:0]    mux_node_o,
    output logic                                    mux_node_valid_o,
    output logic                                    conv_start_o,
    input  wire logic                               conv_done_i,
    input  wire logic [diag_adc_pkg::RESULT_W-1:0]  conv_result_i,
    // status view
    output logic      [diag_adc_pkg::SETUP_W-1:0]   setup_o,
    output logic                                    busy_o
);
    import diag_adc_pkg::*;

    // carrier to the node decoder
    conv_if ci();

    // setup group
    logic [SETUP_W-1:0]  setup_reg;
    logic [SETUP_W-1:0]  setup_next;

    // conversion group
    logic                busy_reg;
    logic                busy_next;
    logic [CHOICE_W-1:0] run_ch_reg;
    logic [CHOICE_W-1:0] run_ch_next;
    logic [CHOICE_W-1:0] result_channel_code_reg;
    logic [CHOICE_W-1:0] result_channel_code_next;
    logic [RESULT_W-1:0] result_reg;
    logic [RESULT_W-1:0] result_next;
    logic                start_reg;
    logic                start_next;
    logic [NODE_W-1:0]   node_reg;
    logic [NODE_W-1:0]   node_next;
    logic                node_valid_reg;
    logic                node_valid_next;
    logic [CNT_W-1:0]    cnt_reg;
    logic [CNT_W-1:0]    cnt_next;

    // status group
    logic [STATUS_W-1:0] frame_status_reg;
    logic [STATUS_W-1:0] frame_status_next;
    logic                frame_valid_reg;
    logic                frame_valid_next;
    logic [STATUS_W-1:0] status_word;

    // command decode
    logic                key_ok;
    logic                accept;
    logic                done;

    // the decoder sees the code of the incoming command, not the stored one,
    // so the node is ready in the same cycle that the start is accepted
    assign ci.choice     = setup_data_i[CHOICE_LSB +: CHOICE_W];
    // sub-choice taken at the write, so the host must have set it before
    assign ci.sub_choice = regulator_die_probe_choice_i;

    node_decode u_decode (
        .ci (ci)
    );

    assign key_ok = (setup_data_i[KEY_HI_LSB +: KEY_W] == KEY_HI_VALUE)
                 && (setup_data_i[KEY_LO_LSB +: KEY_W] == KEY_LO_VALUE);
    assign accept = setup_wr_i && key_ok && !busy_reg;
    // done from the analog side, or the timeout so a silent converter cannot
    // lock out commands for good; the result is then whatever the converter shows
    assign done   = busy_reg && (conv_done_i || (cnt_reg == CNT_W'(1)));

    always_comb begin
        setup_next = setup_reg;
        // a bad key still stores the word, it just starts nothing
        if (setup_wr_i && !busy_reg) begin
            setup_next = setup_data_i;
        end
    end

    // setup register
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            setup_reg <= SETUP_RESET;
        end else begin
            setup_reg <= setup_next;
        end
    end

    // next state of the conversion
    // commands are dropped, not queued, so the host has to watch busy
    always_comb begin
        // hold by default, the start strobe is a one-cycle pulse
        busy_next                = busy_reg;
        run_ch_next              = run_ch_reg;
        result_channel_code_next = result_channel_code_reg;
        result_next              = result_reg;
        start_next               = 1'b0;
        node_next                = node_reg;
        node_valid_next          = node_valid_reg;
        cnt_next                 = cnt_reg;
        if (accept) begin
            node_next       = ci.node;
            node_valid_next = ci.node_valid;
            run_ch_next     = ci.choice;
            busy_next       = 1'b1;
            start_next      = 1'b1;
            cnt_next        = CNT_W'(CONV_CYCLES);
        end else if (done) begin
            result_next              = conv_result_i;
            result_channel_code_next = run_ch_reg;
            busy_next                = 1'b0;
            cnt_next                 = '0;
        end else if (busy_reg) begin
            // timeout count, only while a conversion runs
            cnt_next = cnt_reg - CNT_W'(1);
        end
    end

    // conversion registers
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            // reset leaves no node selected and nothing running
            busy_reg                <= 1'b0;
            run_ch_reg              <= CH_MAIN_TEMP;
            result_channel_code_reg <= CH_MAIN_TEMP;
            result_reg              <= '0;
            start_reg               <= 1'b0;
            node_reg                <= NODE_NONE;
            node_valid_reg          <= 1'b0;
            cnt_reg                 <= '0;
        end else begin
            busy_reg                <= busy_next;
            run_ch_reg              <= run_ch_next;
            result_channel_code_reg <= result_channel_code_next;
            result_reg              <= result_next;
            start_reg               <= start_next;
            node_reg                <= node_next;
            node_valid_reg          <= node_valid_next;
            cnt_reg                 <= cnt_next;
        end
    end

    always_comb begin
        status_word                        = '0;
        status_word[BUSY_BIT]              = busy_reg;
        status_word[CH_LSB +: CHOICE_W]    = result_channel_code_reg;
        status_word[0 +: RESULT_W]         = result_reg;
    end

    always_comb begin
        frame_status_next = frame_status_reg;
        frame_valid_next  = 1'b0;
        if (frame_start_i && auto_status_en_i) begin
            // snapshot of the current status
            // a frame in the cycle of done still sees busy and the old result
            frame_status_next = status_word;
            frame_valid_next  = 1'b1;
        end
    end

    // status registers, held between frames so the front end
    // may shift the snapshot out at its own pace
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            frame_status_reg <= '0;
            frame_valid_reg  <= 1'b0;
        end else begin
            frame_status_reg <= frame_status_next;
            frame_valid_reg  <= frame_valid_next;
        end
    end

    // outputs straight from flops, no decode between flop and pin
    assign frame_status_o       = frame_status_reg;
    assign frame_status_valid_o = frame_valid_reg;
    assign mux_node_o           = node_reg;
    assign mux_node_valid_o     = node_valid_reg;
    assign conv_start_o         = start_reg;
    assign setup_o              = setup_reg;
    assign busy_o               = busy_reg;
endmodule
`default_nettype wire

// File: common/diag_adc_pkg.sv
// constants for the diagnostic converter sequencer
// assumes a single 200 MHz clock domain shared with the serial register logic
package diag_adc_pkg;
    // setup register layout
    localparam int          SETUP_W         = 16;
    localparam int          CHOICE_LSB      = 0;
    localparam int          CHOICE_W        = 5;
    localparam int          KEY_W           = 3;
    localparam int          KEY_HI_LSB      = 8;      // start key upper field, bits 10:8
    localparam int          KEY_LO_LSB      = 5;      // start key lower field, bits 7:5
    localparam logic [2:0]  KEY_HI_VALUE    = 3'h4;   // bits 10:8 = 100
    localparam logic [2:0]  KEY_LO_VALUE    = 3'h0;   // bits 7:5 = 000
    localparam logic [15:0] SETUP_RESET     = 16'h0000;
    // status word layout
    localparam int          STATUS_W        = 18;
    localparam int          BUSY_BIT        = 17;
    localparam int          CH_LSB          = 12;
    localparam int          RESULT_W        = 12;
    // channel codes of note
    localparam logic [4:0]  CH_MAIN_TEMP    = 5'h00;
    localparam logic [4:0]  CH_INT_BANDGAP  = 5'h04;
    localparam logic [4:0]  CH_REG_DIE      = 5'h1E;
    localparam logic [4:0]  CH_REF_OUTPUT   = 5'h1F;
    // regulator die sub-selection
    localparam logic [1:0]  SUB_GROUND      = 2'h0;
    localparam logic [1:0]  SUB_INT_SUPPLY  = 2'h1;
    localparam logic [1:0]  SUB_UPPER_SUPPLY = 2'h2;
    // node select bus: 0..31 main codes, 32..34 regulator die nodes
    localparam int          NODE_W          = 6;
    localparam logic [5:0]  NODE_NONE       = 6'h3F;
    localparam logic [5:0]  NODE_REG_BASE   = 6'h20;
    // conversion time (model of analog latency)
    localparam int          CONV_TIME_NS    = 2000;
    localparam int          CLK_PERIOD_NS   = 5;
    localparam int          CONV_CYCLES     = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          CNT_W           = 10;
endpackage

// File: common/conv_if.sv
// carrier between the sequencer and its node decoder
// assumes both ends sit on the same clock
`timescale 1ns/1ps
`default_nettype none
interface conv_if;
    logic [4:0] choice;
    logic [1:0] sub_choice;
    logic [5:0] node;
    logic       node_valid;
    modport seq (output choice, output sub_choice, input node, input node_valid);
    modport dec (input choice, input sub_choice, output node, output node_valid);
endinterface
`default_nettype wire

// File: core/node_decode.sv
// maps a channel code and regulator sub-choice to a multiplexer node
// assumes combinational use within the sequencer's clock cycle
`timescale 1ns/1ps
`default_nettype none
module node_decode (
    conv_if.dec ci
);
    import diag_adc_pkg::*;

    // reserved codes give no node
    always_comb begin
        ci.node       = NODE_NONE;
        ci.node_valid = 1'b0;
        case (ci.choice)
            5'h02, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0F,
            5'h10, 5'h11, 5'h12, 5'h13, 5'h17: begin
                ci.node_valid = 1'b0;
            end
            CH_REG_DIE: begin
                if (ci.sub_choice != 2'h3) begin
                    ci.node       = NODE_REG_BASE + {4'h0, ci.sub_choice};
                    ci.node_valid = 1'b1;
                end
            end
            default: begin
                ci.node       = {1'b0, ci.choice};
                ci.node_valid = 1'b1;
            end
        endcase
    end
endmodule
`default_nettype wire

// File: verification/conv_model.sv
// converter stand-in: answers each start pulse after a set delay
// assumes the sequencer clock and a one-cycle start pulse
`timescale 1ns/1ps
`default_nettype none
module conv_model (
    // control
    input  wire logic        clk_i,
    input  wire logic        start_i,
    input  wire logic [5:0]  node_i,
    input  wire logic [9:0]  delay_i,
    // answer
    output logic             done_o = 1'b0,
    output logic [11:0]      result_o = 12'h5A5
);
    logic [9:0] cnt_reg = 10'h000;
    logic       run_reg = 1'b0;
    // result toggles outside done so a stale read cannot pass
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        result_o <= ~result_o;
        if (start_i) begin
            run_reg <= 1'b1;
            cnt_reg <= delay_i;
        end else if (run_reg && cnt_reg == 10'h000) begin
            run_reg <= 1'b0;
            done_o <= 1'b1;
            result_o <= {6'h2A, node_i};
        end else if (run_reg) begin
            cnt_reg <= cnt_reg - 10'h001;
        end
    end
endmodule
`default_nettype wire

// File: verification/diag_adc_sequencer_monitor.sv
// port assertions for the converter sequencer
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module diag_adc_sequencer_monitor (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // command side
    input  wire logic        setup_wr_i,
    input  wire logic [15:0] setup_data_i,
    input  wire logic [1:0]  regulator_die_probe_choice_i,
    input  wire logic        frame_start_i,
    input  wire logic        auto_status_en_i,
    input  wire logic        conv_done_i,
    // design outputs
    input  wire logic        frame_status_valid_o,
    input  wire logic [17:0] frame_status_o,
    input  wire logic [5:0]  mux_node_o,
    input  wire logic        mux_node_valid_o,
    input  wire logic        conv_start_o,
    input  wire logic [15:0] setup_o,
    input  wire logic        busy_o
);
    import diag_adc_pkg::*;
    logic key_ok;
    // start key in bits 10:5
    assign key_ok = setup_data_i[KEY_HI_LSB +: KEY_W] == KEY_HI_VALUE
                 && setup_data_i[KEY_LO_LSB +: KEY_W] == KEY_LO_VALUE;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    cmd_start_a: assert property (setup_wr_i && key_ok && !busy_o |=> conv_start_o && busy_o)
        else $error("accepted command did not start");
    start_pulse_a: assert property (conv_start_o |=> !conv_start_o)
        else $error("start pulse longer than one cycle");
    busy_drop_a: assert property (busy_o |=> !conv_start_o)
        else $error("start while busy");
    busy_setup_a: assert property (setup_wr_i && busy_o |=> $stable(setup_o))
        else $error("setup stored while busy");
    bad_key_a: assert property (setup_wr_i && !key_ok |=> !conv_start_o)
        else $error("start on bad key");
    done_clear_a: assert property (busy_o && conv_done_i |=> !busy_o)
        else $error("busy kept after done");
    choice_node_a: assert property (conv_start_o && mux_node_valid_o && setup_o[4:0] != CH_REG_DIE
        |-> mux_node_o == {1'b0, setup_o[4:0]})
        else $error("node differs from code");
    die_node_a: assert property (conv_start_o && setup_o[4:0] == CH_REG_DIE
        && $past(regulator_die_probe_choice_i) != 2'h3
        |-> mux_node_o == NODE_REG_BASE + {4'h0, $past(regulator_die_probe_choice_i)})
        else $error("regulator node wrong");
    frame_valid_a: assert property (frame_start_i && auto_status_en_i |=> frame_status_valid_o)
        else $error("no status in frame");
    frame_busy_a: assert property (frame_start_i && auto_status_en_i |=> frame_status_o[BUSY_BIT] == $past(busy_o))
        else $error("status busy bit wrong");
endmodule
bind diag_adc_sequencer diag_adc_sequencer_monitor mon (.clk_i, .rst_n_i, .setup_wr_i, .frame_start_i,
    .auto_status_en_i, .frame_status_valid_o, .mux_node_valid_o, .conv_start_o, .conv_done_i, .busy_o,
    .setup_data_i, .setup_o, .regulator_die_probe_choice_i, .frame_status_o, .mux_node_o);
`default_nettype wire

// File: verification/tb.sv
// bench for the converter sequencer: setup writes and status frames
// assumes the converter stand-in answers every start pulse
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        n_mismatch++; \
        $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
end
module tb;
    import diag_adc_pkg::*;
    logic clk_i = 1'b0, rst_n_i = 1'b0, setup_wr_i = 1'b0, frame_start_i = 1'b0, auto_en = 1'b1;
    logic [15:0] setup_data_i = 16'h0000, setup_o;
    logic [1:0]  sub = 2'h0;
    logic [17:0] frame_status_o;
    logic [11:0] conv_result_i;
    logic [5:0]  mux_node_o;
    logic [9:0]  delay = 10'h003;
    logic        frame_status_valid_o, mux_node_valid_o, conv_start_o, conv_done_i, busy_o;
    int          n_mismatch = 0, total_checks = 0;
    logic [4:0]  codes [8] = '{5'h00, 5'h04, 5'h1F, 5'h02, 5'h1E, 5'h1E, 5'h1E, 5'h1E};
    logic [1:0]  subs [8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
    logic [5:0]  nodes [8] = '{6'h00, 6'h04, 6'h1F, 6'h3F, 6'h20, 6'h21, 6'h22, 6'h3F};
    always #2.5 clk_i = ~clk_i;
    diag_adc_sequencer uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .setup_wr_i(setup_wr_i), .setup_data_i(setup_data_i),
        .regulator_die_probe_choice_i(sub), .frame_start_i(frame_start_i), .auto_status_en_i(auto_en),
        .frame_status_o(frame_status_o), .frame_status_valid_o(frame_status_valid_o), .mux_node_o(mux_node_o),
        .mux_node_valid_o(mux_node_valid_o), .conv_start_o(conv_start_o), .conv_done_i(conv_done_i),
        .conv_result_i(conv_result_i), .setup_o(setup_o), .busy_o(busy_o));
    conv_model adc (.clk_i(clk_i), .start_i(conv_start_o), .node_i(mux_node_o), .delay_i(delay),
        .done_o(conv_done_i), .result_o(conv_result_i));
    function automatic logic [17:0] st(input logic [4:0] c, input logic [5:0] n);
        return {1'b0, c, 6'h2A, n};
    endfunction
    task automatic stop_test;
        if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // sub-choice goes out a cycle ahead of the write
    task automatic cmd(input logic [4:0] c, input logic [1:0] s, input logic frm, input logic [2:0] hi);
        @(posedge clk_i);
        sub <= s;
        @(posedge clk_i);
        setup_data_i <= {5'h00, hi, 3'h0, c};
        setup_wr_i <= 1'b1;
        frame_start_i <= frm;
        @(posedge clk_i);
        setup_wr_i <= 1'b0;
        frame_start_i <= 1'b0;
        #1;
    endtask
    task automatic frame(input logic en);
        @(posedge clk_i);
        auto_en <= en;
        frame_start_i <= 1'b1;
        @(posedge clk_i);
        frame_start_i <= 1'b0;
        #1;
    endtask
    task automatic idle;
        for (int i = 0; i < 500 && busy_o !== 1'b0; i++) @(posedge clk_i);
        #1;
        `CHK("busy", 1'b0, busy_o)
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        frame(1'b1);
        `CHK("reset status", 18'h00000, frame_status_o)
        frame(1'b0);
        `CHK("mode off", 1'b0, frame_status_valid_o)
        foreach (codes[k]) begin
            cmd(codes[k], subs[k], 1'b0, 3'h4);
            `CHK("start", 1'b1, conv_start_o)
            `CHK("node", nodes[k], mux_node_o)
            `CHK("node ok", nodes[k] != 6'h3F, mux_node_valid_o)
            idle();
            frame(1'b1);
            `CHK("status", st(codes[k], nodes[k]), frame_status_o)
        end
        cmd(5'h04, 2'h0, 1'b0, 3'h5);
        `CHK("bad key", 1'b0, conv_start_o)
        `CHK("bad key setup", 16'h0504, setup_o)
        delay = 10'h032;
        cmd(5'h04, 2'h0, 1'b1, 3'h4);
        `CHK("cmd frame", st(5'h1E, 6'h3F), frame_status_o)
        frame(1'b1);
        `CHK("busy frame", st(5'h1E, 6'h3F) | 18'h20000, frame_status_o)
        cmd(5'h1F, 2'h0, 1'b0, 3'h4);
        `CHK("busy cmd", 1'b0, conv_start_o)
        `CHK("busy setup", 16'h0404, setup_o)
        idle();
        // a queued command would have started by now and still be running
        repeat (10) @(posedge clk_i);
        #1;
        `CHK("no queue", 1'b0, busy_o)
        frame(1'b1);
        `CHK("new status", st(5'h04, 6'h04), frame_status_o)
        stop_test();
    end
    // hang guard, well past the expected run
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end
endmodule
`default_nettype wire
